// [core/oms_top.sv]
// Oscillator mode select: source decode and pin ownership
`timescale 1ns/1ps
`include "oms_cfg.svh"
// Function
// [R1] Decode three-bit field into four sources
// [R2] RC modes: low bit picks port or output
// [R3] External RC uses oscillator input pin
// [R4] Internal RC frees port5 bit5 pin
// [R5] Crystal modes dedicate both oscillator pins
// [R6] Unprogrammed field means high-frequency crystal
// [R7] Internal RC defaults 4MHz, alternatives selectable
// [R8] Outside clock may drive oscillator input
// [R9] Select 11=4M, 10=8M, 01=1M, 00=455k
module oms_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cfg_load_i,
  input wire logic clk_src_sel_b2_i,
  input wire logic clk_src_sel_b1_i,
  input wire logic clk_src_sel_b0_i,
  input wire logic rc_freq_sel_hi_i,
  input wire logic rc_freq_sel_lo_i,
  output oms_pkg::oms_src_t clk_src_o,
  output oms_pkg::oms_rcf_t rc_freq_o,
  output logic high_freq_crystal_mode_o,
  output logic low_freq_crystal_mode_o,
  output logic external_rc_mode_o,
  output logic internal_rc_mode_o,
  output logic osc_in_used_o,
  output logic oscillator_out_pin_en_o,
  output logic port7_bit0_gpio_o,
  output logic port5_bit5_gpio_o,
  output logic mode_invalid_o
);
  import oms_pkg::*;

  logic [2:0] mode_q;
  logic [1:0] rcf_q;
  logic [2:0] mode_d;
  logic [1:0] rcf_d;

  // Decode shared with the valid check
  function automatic logic mode_legal(input logic [2:0] m);
    mode_legal = (m[2] == 1'b0) || (m[2:1] == 2'b11);
  endfunction : mode_legal

  // Configuration word latched on every clock with cfg_load_i high and rst_i low; rst_i high loads the default; holds otherwise as fixed before run
  // time. Illegal codes (100/101) fall back to the unprogrammed default.
  assign mode_d = cfg_load_i ?
    (mode_legal({clk_src_sel_b2_i, clk_src_sel_b1_i, clk_src_sel_b0_i}) ?
     {clk_src_sel_b2_i, clk_src_sel_b1_i, clk_src_sel_b0_i} : `OMS_MODE_RESET) :
    mode_q; // [R6]
  assign rcf_d = cfg_load_i ? {rc_freq_sel_hi_i, rc_freq_sel_lo_i} : rcf_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_q <= `OMS_MODE_RESET; // [R6]
      rcf_q <= `OMS_RCF_RESET; // [R7]
    end else begin
      mode_q <= mode_d;
      rcf_q <= rcf_d;
    end
  end

  logic is_erc;
  logic is_irc;
  logic is_lxt;
  logic is_hxt;
  assign is_erc = (mode_q[2:1] == 2'b00); // [R1]
  assign is_irc = (mode_q[2:1] == 2'b01); // [R1]
  assign is_lxt = (mode_q == `OMS_MODE_LXT); // [R1]
  assign is_hxt = (mode_q == `OMS_MODE_HXT); // [R1]

  assign clk_src_o = is_erc ? OMS_SRC_ERC : is_irc ? OMS_SRC_IRC :
                     is_lxt ? OMS_SRC_LXT : OMS_SRC_HXT;
  assign high_freq_crystal_mode_o = is_hxt;
  assign low_freq_crystal_mode_o = is_lxt;
  assign external_rc_mode_o = is_erc;
  assign internal_rc_mode_o = is_irc;
  assign mode_invalid_o = ~mode_legal(mode_q);

  // Input pin is the oscillator connection in every mode except internal RC;
  // the same pin also takes an outside clock in place of a crystal.
  assign osc_in_used_o = ~is_irc; // [R3] [R8]
  // Crystals own the output pin; RC modes let bit 0 pick
  assign oscillator_out_pin_en_o = (is_lxt | is_hxt) | ((is_erc | is_irc) & mode_q[0]); // [R2] [R5]
  assign port7_bit0_gpio_o = (is_erc | is_irc) & ~mode_q[0]; // [R2] [R5]
  assign port5_bit5_gpio_o = is_irc; // [R4]

  oms_rc_freq u_rcf (
    .sel_i(rcf_q),
    .freq_o(rc_freq_o)
  ); // [R7]

  a_gpio_excl: assert property (@(posedge clock_i) disable iff (rst_i) // [R2]
    !(port7_bit0_gpio_o && oscillator_out_pin_en_o)) else $error("pin both gpio and osc");
  a_xtal_pins: assert property (@(posedge clock_i) disable iff (rst_i) // [R5]
    (is_lxt || is_hxt) |-> (!port7_bit0_gpio_o && !port5_bit5_gpio_o && osc_in_used_o))
    else $error("crystal pins offered as gpio");
  a_rc_lowbit: assert property (@(posedge clock_i) disable iff (rst_i) // [R2]
    (mode_q[2] == 1'b0) |-> (oscillator_out_pin_en_o == mode_q[0]))
    else $error("rc low bit pin select wrong");
  a_erc_input: assert property (@(posedge clock_i) disable iff (rst_i) // [R3]
    external_rc_mode_o |-> osc_in_used_o) else $error("erc input pin unused");
  a_irc_p55: assert property (@(posedge clock_i) disable iff (rst_i) // [R4]
    port5_bit5_gpio_o == internal_rc_mode_o) else $error("p55 release wrong");
  a_reset_hxt: assert property (@(posedge clock_i) // [R6]
    $past(rst_i) |-> (high_freq_crystal_mode_o && rc_freq_o == OMS_F_4M))
    else $error("reset default wrong");
  a_load_mode: assert property (@(posedge clock_i) disable iff (rst_i) // [R1]
    (cfg_load_i && {clk_src_sel_b2_i, clk_src_sel_b1_i} == 2'b01) |=> internal_rc_mode_o)
    else $error("irc decode wrong");
  a_hold_mode: assert property (@(posedge clock_i) disable iff (rst_i)
    !cfg_load_i |=> $stable(clk_src_o)) else $error("mode changed without load");
  a_rcf_map: assert property (@(posedge clock_i) disable iff (rst_i) // [R9]
    (cfg_load_i && !rc_freq_sel_hi_i && !rc_freq_sel_lo_i) |=> rc_freq_o == OMS_F_455K)
    else $error("455k encode wrong");
  a_rcf_4m: assert property (@(posedge clock_i) disable iff (rst_i) // [R9]
    (cfg_load_i && rc_freq_sel_hi_i && rc_freq_sel_lo_i) |=> rc_freq_o == OMS_F_4M)
    else $error("4M encode wrong");
  a_rcf_8m: assert property (@(posedge clock_i) disable iff (rst_i) // [R9]
    (cfg_load_i && rc_freq_sel_hi_i && !rc_freq_sel_lo_i) |=> rc_freq_o == OMS_F_8M)
    else $error("8M encode wrong");
  a_rcf_1m: assert property (@(posedge clock_i) disable iff (rst_i) // [R9]
    (cfg_load_i && !rc_freq_sel_hi_i && rc_freq_sel_lo_i) |=> rc_freq_o == OMS_F_1M)
    else $error("1M encode wrong");
  a_lxt_decode: assert property (@(posedge clock_i) disable iff (rst_i) // [R1]
    (cfg_load_i && clk_src_sel_b2_i && clk_src_sel_b1_i && !clk_src_sel_b0_i)
    |=> low_freq_crystal_mode_o) else $error("lxt decode wrong");
  a_erc_decode: assert property (@(posedge clock_i) disable iff (rst_i) // [R1]
    (cfg_load_i && !clk_src_sel_b2_i && !clk_src_sel_b1_i) |=> external_rc_mode_o)
    else $error("erc decode wrong");
  // Codes 100 and 101 have no mode of their own
  a_illegal_hxt: assert property (@(posedge clock_i) disable iff (rst_i) // [R6]
    (cfg_load_i && clk_src_sel_b2_i && !clk_src_sel_b1_i) |=> high_freq_crystal_mode_o)
    else $error("illegal code not mapped");
  a_mode_onehot: assert property (@(posedge clock_i) disable iff (rst_i) // [R1]
    $onehot({high_freq_crystal_mode_o, low_freq_crystal_mode_o, external_rc_mode_o,
             internal_rc_mode_o})) else $error("mode flags not one-hot");
  a_xtal_out: assert property (@(posedge clock_i) disable iff (rst_i) // [R5]
    (low_freq_crystal_mode_o || high_freq_crystal_mode_o) |-> oscillator_out_pin_en_o)
    else $error("crystal output pin released");
  a_mode_valid: assert property (@(posedge clock_i) disable iff (rst_i) // [R6]
    !mode_invalid_o) else $error("stored mode illegal");
endmodule : oms_top

// [core/oms_cfg.svh]
// Constants for the oscillator mode select block
`ifndef OMS_CFG_SVH
`define OMS_CFG_SVH
`define OMS_MODE_ERC_IO   3'h0
`define OMS_MODE_ERC_OUT  3'h1
`define OMS_MODE_IRC_IO   3'h2
`define OMS_MODE_IRC_OUT  3'h3
`define OMS_MODE_LXT      3'h6
`define OMS_MODE_HXT      3'h7
`define OMS_MODE_RESET    3'h7
`define OMS_RCF_4MHZ      2'h3
`define OMS_RCF_8MHZ      2'h2
`define OMS_RCF_1MHZ      2'h1
`define OMS_RCF_455KHZ    2'h0
`define OMS_RCF_RESET     2'h3
`endif

// [core/oms_pkg.sv]
// Types for the oscillator mode select block
package oms_pkg;
  typedef enum logic [1:0] {
    OMS_SRC_HXT,
    OMS_SRC_LXT,
    OMS_SRC_ERC,
    OMS_SRC_IRC
  } oms_src_t;
  typedef enum logic [1:0] {
    OMS_F_455K,
    OMS_F_1M,
    OMS_F_4M,
    OMS_F_8M
  } oms_rcf_t;
endpackage : oms_pkg

// [core/oms_rc_freq.sv]
// Internal RC frequency select decoder
`timescale 1ns/1ps
`include "oms_cfg.svh"
module oms_rc_freq (
  input wire logic [1:0] sel_i,
  output oms_pkg::oms_rcf_t freq_o
);
  import oms_pkg::*;
  // Encoding of the two select bits
  assign freq_o = (sel_i == `OMS_RCF_4MHZ) ? OMS_F_4M :
                  (sel_i == `OMS_RCF_8MHZ) ? OMS_F_8M :
                  (sel_i == `OMS_RCF_1MHZ) ? OMS_F_1M : OMS_F_455K; // [R9]
endmodule : oms_rc_freq

// [tb/oms_ext_clk.sv]
// Outside clock source driving the oscillator input pin
`timescale 1ns/1ps
module oms_ext_clk (
  input wire logic osc_in_used_i,
  output logic ext_clk_o
);
  initial begin
    ext_clk_o = 1'b0;
    // Stands low while the input pin is not an oscillator input
    forever #31 ext_clk_o = osc_in_used_i ? ~ext_clk_o : 1'b0;
  end
endmodule : oms_ext_clk

// [tb/oscillator_mode_select_test.sv]
// Self-checking bench for the oscillator mode select block
`timescale 1ns/1ps
`define CHK(g, e) if ((g) !== (e)) begin n_mismatch++; $display("mismatch %0t %h %h", $time, g, e); end compares++
module oscillator_mode_select_test;
  import oms_pkg::*;
  logic clock_i, rst_i, cfg_load_i, ext_clk;
  logic [2:0] m;
  logic [1:0] r;
  oms_src_t src;
  oms_rcf_t rcf;
  logic high_freq_crystal_mode, low_freq_crystal_mode, external_rc_mode, internal_rc_mode, in_used, out_en, p70, p55, inval;
  logic [12:0] q[$];
  logic [12:0] exp_v;
  int n_mismatch = 0;
  int compares = 0;
  wire [12:0] got = {src, rcf, high_freq_crystal_mode, low_freq_crystal_mode, external_rc_mode, internal_rc_mode, in_used, out_en, p70, p55, inval};
  oms_top oms_top_i (.clock_i(clock_i), .rst_i(rst_i), .cfg_load_i(cfg_load_i),
    .clk_src_sel_b2_i(m[2]), .clk_src_sel_b1_i(m[1]), .clk_src_sel_b0_i(m[0]),
    .rc_freq_sel_hi_i(r[1]), .rc_freq_sel_lo_i(r[0]), .clk_src_o(src), .rc_freq_o(rcf),
    .high_freq_crystal_mode_o(high_freq_crystal_mode), .low_freq_crystal_mode_o(low_freq_crystal_mode), .external_rc_mode_o(external_rc_mode),
    .internal_rc_mode_o(internal_rc_mode), .osc_in_used_o(in_used), .oscillator_out_pin_en_o(out_en),
    .port7_bit0_gpio_o(p70), .port5_bit5_gpio_o(p55), .mode_invalid_o(inval));
  oms_ext_clk oms_ext_clk_i (.osc_in_used_i(in_used), .ext_clk_o(ext_clk));
  function automatic logic [12:0] expv(input logic [2:0] c, input logic [1:0] f);
    oms_src_t s;
    oms_rcf_t k;
    logic rc;
    s = (c == 3'h6) ? OMS_SRC_LXT : (c[2:1] == 2'h0) ? OMS_SRC_ERC :
        (c[2:1] == 2'h1) ? OMS_SRC_IRC : OMS_SRC_HXT;
    k = (f == 2'h3) ? OMS_F_4M : (f == 2'h2) ? OMS_F_8M : (f == 2'h1) ? OMS_F_1M : OMS_F_455K;
    rc = (s == OMS_SRC_ERC) || (s == OMS_SRC_IRC);
    return {s, k, s == OMS_SRC_HXT, s == OMS_SRC_LXT, s == OMS_SRC_ERC, s == OMS_SRC_IRC,
            s != OMS_SRC_IRC, !rc | c[0], rc & !c[0], s == OMS_SRC_IRC, 1'b0};
  endfunction : expv
  task automatic load(input logic [2:0] c, input logic [1:0] f);
    @(posedge clock_i);
    #2;
    m = c;
    r = f;
    cfg_load_i = 1'b1;
    q.push_back(expv(c, f));
  endtask : load
  task automatic wrap_up;
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // One time unit after each capturing edge the outputs carry the new setting
  always @(posedge clock_i) begin
    if (cfg_load_i && !rst_i && q.size() > 0) begin
      #1;
      exp_v = q.pop_front();
      `CHK(got, exp_v);
    end
  end
  initial begin
    rst_i = 1'b1;
    cfg_load_i = 1'b0;
    m = 3'h0;
    r = 2'h0;
    void'($urandom(56));
    repeat (12) @(posedge clock_i);
    #2;
    rst_i = 1'b0;
    `CHK(got, expv(3'h7, 2'h3));
    for (int i = 0; i < 16; i++) load(i[2:0], 2'($urandom));
    for (int i = 0; i < 4; i++) load(3'($urandom), i[1:0]);
    @(posedge clock_i);
    #2;
    cfg_load_i = 1'b0;
    rst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #2;
    rst_i = 1'b0;
    `CHK(got, expv(3'h7, 2'h3));
    for (int k = 0; k < 8 && q.size() > 0; k++) @(posedge clock_i);
    if (q.size() > 0) n_mismatch++;
    wrap_up();
  end
endmodule : oscillator_mode_select_test
